// >>> hw/fss_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes: included by the sequencer, the host model and the bench
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

// register byte offsets
`define FSS_CTRL_OFS 8'h00
`define FSS_DECEL_OFS 8'h04
`define FSS_ZERO_OFS 8'h08
`define FSS_DELAY_OFS 8'h0c
`define FSS_CMD_OFS 8'h10
`define FSS_STAT_OFS 8'h14
`define FSS_ISTAT_OFS 8'h18
`define FSS_IMASK_OFS 8'h1c

// stop mode digit values
`define FSS_MODE_DECEL 4'h2
`define FSS_MODE_NODECEL 4'h0

// reset values
`define FSS_DECEL_RST 16'h0010
`define FSS_ZERO_RST 16'h0032
`define FSS_DELAY_RST 16'h0000

// command bits
`define FSS_CMD_ERR_BIT 0
`define FSS_CMD_CPU_BIT 1

// alarm codes and interrupt bits
`define FSS_ALM_STO_TIMING 8'h3f
`define FSS_INT_ALARM 0
`define FSS_INT_STOP 1
`define FSS_INT_HALT 2
`define FSS_INT_W 3

`endif

// >>> hw/fss_pkg.sv
// Purpose: shared types of the alarm and forced-stop sequencer
// Assumes: nothing beyond the constants header
// Notes: states and carriers only
package fss_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_DECEL,
        ST_WAIT,
        ST_STOP
    } fss_state_type;

    // power stage drive group
    typedef struct packed {
        logic power_on;
        logic dyn_brake;
        logic interlock;
    } fss_drive_type;
endpackage

// >>> hw/fss_ramp.sv
// Purpose: model speed reference stepping toward zero
// Assumes: step is a magnitude, value is signed
// Notes: clamps at zero, never overshoots
`timescale 1ns/100ps
module fss_ramp #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // control
    input wire logic i_load,
    input wire logic signed [W-1:0] i_load_val,
    input wire logic i_run,
    input wire logic [W-1:0] i_step,
    // result
    output logic signed [W-1:0] o_value
);
    logic signed [W:0] mag_next;
    logic signed [W:0] wide;

    // distance toward zero after one step
    always_comb
    begin
        wide = {o_value[W-1], o_value};
        if (o_value[W-1])
            mag_next = wide + $signed({1'b0, i_step});
        else
            mag_next = wide - $signed({1'b0, i_step});
    end

    // value register
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_value <= '0;
        else if (i_load)
            o_value <= i_load_val;
        else if (i_run)
        begin
            if (mag_next[W] != wide[W] || mag_next == '0)
                o_value <= '0; // crossed or reached zero
            else
                o_value <= mag_next[W-1:0];
        end
    end
endmodule

// >>> hw/fss_sequencer.sv
// Purpose: alarm and forced-stop sequencing of a servo drive
// Assumes: all inputs synchronous to i_clock, 40 MHz
// Notes: apb slave answers with no wait state
// Behaviour
// - dynamic-brake alarms skip deceleration, brake at once
// - torque-off during deceleration raises alarm 63
// - alarm cleared only by reset or host reset
// - no clear while alarm cause persists
// - torque mode never decelerates, stops directly
// - stop mode 2 enables deceleration, 0 disables
// - deceleration drives internal ramp, not host command
// - link loss decelerates, or brakes if flagged
// - deceleration disabled: stop directly, no ramp
// - below zero speed: cut drive, engage brake
// - programmable delay from interlock off to cutoff
// - forced stop decelerates at programmed rate
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "fss_consts.svh"
module fss_sequencer
    import fss_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // stop sources
    input wire logic i_forced_stop_input_n,
    input wire logic i_safe_torque_off_input_n,
    input wire logic i_link_lost,
    input wire logic i_link_lost_brake,
    input wire logic i_alarm_evt,
    input wire logic [7:0] i_alarm_code,
    input wire logic i_alarm_brake,
    input wire logic i_alarm_cause,
    input wire logic i_torque_mode,
    // speeds
    input wire logic signed [W-1:0] i_host_speed,
    input wire logic signed [W-1:0] i_motor_speed,
    // drive outputs
    output logic signed [W-1:0] o_speed_ref,
    output fss_drive_type o_drive,
    output logic o_fault_output,
    output logic [7:0] o_alarm_code,
    output logic o_irq
);
    fss_state_type state_reg;
    logic [3:0] mode_reg;
    logic [W-1:0] decel_reg;
    logic [W-1:0] zero_reg;
    logic [W-1:0] delay_reg;
    logic [W-1:0] wait_cnt_reg;
    logic [`FSS_INT_W-1:0] istat_reg;
    logic [`FSS_INT_W-1:0] imask_reg;
    logic alarm_reg;
    logic [7:0] code_reg;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic clear_cmd;
    logic cause_now;
    logic sto_alarm;
    logic new_alarm;
    logic stop_req;
    logic brake_now;
    logic decel_en;
    logic signed [W-1:0] ramp_val;
    logic [W-1:0] motor_abs;
    logic below_zero;
    logic [`FSS_INT_W-1:0] int_evt;

    ////////////////////////////////////////////////////////////////
    // apb decode
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;

    // address map check
    always_comb
    begin
        case (i_paddr)
            `FSS_CTRL_OFS, `FSS_DECEL_OFS, `FSS_ZERO_OFS, `FSS_DELAY_OFS,
            `FSS_CMD_OFS, `FSS_STAT_OFS, `FSS_ISTAT_OFS, `FSS_IMASK_OFS:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // configuration registers
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            mode_reg <= `FSS_MODE_DECEL;
            decel_reg <= W'(`FSS_DECEL_RST);
            zero_reg <= W'(`FSS_ZERO_RST);
            delay_reg <= W'(`FSS_DELAY_RST);
            imask_reg <= '0;
        end
        else if (wr_en)
        begin
            case (i_paddr)
                `FSS_CTRL_OFS: mode_reg <= i_pwdata[3:0];
                `FSS_DECEL_OFS: decel_reg <= i_pwdata[W-1:0];
                `FSS_ZERO_OFS: zero_reg <= i_pwdata[W-1:0];
                `FSS_DELAY_OFS: delay_reg <= i_pwdata[W-1:0];
                `FSS_IMASK_OFS: imask_reg <= i_pwdata[`FSS_INT_W-1:0];
                default: ;
            endcase
        end
    end

    // read data register
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_prdata <= '0;
        else if (i_psel && !i_penable && !i_pwrite)
        begin
            case (i_paddr)
                `FSS_CTRL_OFS: o_prdata <= {28'h0, mode_reg};
                `FSS_DECEL_OFS: o_prdata <= 32'(decel_reg);
                `FSS_ZERO_OFS: o_prdata <= 32'(zero_reg);
                `FSS_DELAY_OFS: o_prdata <= 32'(delay_reg);
                `FSS_STAT_OFS: o_prdata <= {16'h0, code_reg, 2'h0, alarm_reg,
                    o_drive, state_reg};
                `FSS_ISTAT_OFS: o_prdata <= 32'(istat_reg);
                `FSS_IMASK_OFS: o_prdata <= 32'(imask_reg);
                default: o_prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // alarm latch and clearing
    assign clear_cmd = wr_en && i_paddr == `FSS_CMD_OFS
        && (i_pwdata[`FSS_CMD_ERR_BIT] || i_pwdata[`FSS_CMD_CPU_BIT]);
    assign sto_alarm = state_reg == ST_DECEL && !i_safe_torque_off_input_n;
    assign new_alarm = (i_alarm_evt || sto_alarm) && !alarm_reg;
    assign cause_now = i_alarm_cause
        || (code_reg == `FSS_ALM_STO_TIMING && !i_safe_torque_off_input_n);

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            alarm_reg <= 1'b0;
            code_reg <= '0;
        end
        else if (new_alarm)
        begin
            alarm_reg <= 1'b1;
            code_reg <= sto_alarm ? `FSS_ALM_STO_TIMING : i_alarm_code;
        end
        else if (alarm_reg && clear_cmd && !cause_now)
        begin
            alarm_reg <= 1'b0;
            code_reg <= '0;
        end
    end

    assign o_fault_output = alarm_reg;
    assign o_alarm_code = code_reg;

    ////////////////////////////////////////////////////////////////
    // stop decision
    assign decel_en = mode_reg == `FSS_MODE_DECEL && !i_torque_mode;
    assign stop_req = !i_forced_stop_input_n || i_link_lost || alarm_reg
        || i_alarm_evt;
    assign brake_now = (i_alarm_evt && i_alarm_brake)
        || (i_link_lost && i_link_lost_brake)
        || !decel_en;
    assign motor_abs = i_motor_speed[W-1] ? W'(-i_motor_speed) : i_motor_speed;
    assign below_zero = motor_abs < zero_reg;

    // sequencer state
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            state_reg <= ST_RUN;
        else
        begin
            case (state_reg)
                ST_RUN:
                    if (stop_req)
                        state_reg <= brake_now ? ST_STOP : ST_DECEL;
                ST_DECEL:
                    if (sto_alarm || (i_alarm_evt && i_alarm_brake))
                        state_reg <= ST_STOP;
                    else if (below_zero)
                        state_reg <= ST_WAIT;
                ST_WAIT:
                    if (wait_cnt_reg >= delay_reg)
                        state_reg <= ST_STOP;
                ST_STOP:
                    if (!stop_req)
                        state_reg <= ST_RUN;
                default:
                    state_reg <= ST_STOP;
            endcase
        end
    end

    // interlock to cutoff delay counter
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            wait_cnt_reg <= '0;
        else if (state_reg == ST_WAIT)
            wait_cnt_reg <= wait_cnt_reg + W'(1);
        else
            wait_cnt_reg <= '0;
    end

    ////////////////////////////////////////////////////////////////
    // model speed ramp
    fss_ramp #(
        .W(W)
    ) u_ramp (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_load(state_reg != ST_DECEL),
        .i_load_val(i_motor_speed),
        .i_run(state_reg == ST_DECEL),
        .i_step(decel_reg),
        .o_value(ramp_val)
    );

    // speed reference and drive outputs
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_speed_ref <= '0;
        else if (state_reg == ST_DECEL)
            o_speed_ref <= ramp_val;
        else if (state_reg == ST_RUN && !alarm_reg && !stop_req)
            o_speed_ref <= i_host_speed;
        else
            o_speed_ref <= '0;
    end

    // power stage, dynamic brake and interlock
    always_comb
    begin
        o_drive.power_on = state_reg != ST_STOP;
        o_drive.dyn_brake = state_reg == ST_STOP;
        o_drive.interlock = state_reg == ST_RUN || state_reg == ST_DECEL;
    end

    ////////////////////////////////////////////////////////////////
    // interrupt status, set wins over write-one clear
    assign int_evt = {state_reg == ST_WAIT && wait_cnt_reg >= delay_reg,
        state_reg == ST_RUN && stop_req, new_alarm};

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            istat_reg <= '0;
        else if (wr_en && i_paddr == `FSS_ISTAT_OFS)
            istat_reg <= (istat_reg & ~i_pwdata[`FSS_INT_W-1:0]) | int_evt;
        else
            istat_reg <= istat_reg | int_evt;
    end

    assign o_irq = |(istat_reg & imask_reg);

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    immediate_db_a: assert property (
        state_reg == ST_RUN && i_alarm_evt && i_alarm_brake
        |=> state_reg == ST_STOP && o_drive.dyn_brake)
        else $error("brake alarm did not brake at once");
    sto_alarm_a: assert property (
        state_reg == ST_DECEL && !i_safe_torque_off_input_n && !alarm_reg
        |=> alarm_reg && code_reg == 8'h3f)
        else $error("torque-off timing alarm missing");
    alarm_hold_a: assert property (
        alarm_reg && !clear_cmd |=> alarm_reg)
        else $error("alarm dropped without reset");
    cause_hold_a: assert property (
        alarm_reg && cause_now |=> alarm_reg)
        else $error("alarm cleared with cause present");
    torque_direct_a: assert property (
        state_reg == ST_RUN && i_torque_mode |=> state_reg != ST_DECEL)
        else $error("decelerated in torque mode");
    mode_decel_a: assert property (
        state_reg == ST_RUN && !i_forced_stop_input_n && mode_reg == 4'h2
        && !i_torque_mode && !i_alarm_evt && !i_link_lost |=> state_reg == ST_DECEL)
        else $error("decel mode did not decelerate");
    ramp_down_a: assert property (
        state_reg == ST_DECEL && $past(state_reg == ST_DECEL, 2)
        |-> (o_speed_ref[W-1] ? -o_speed_ref : o_speed_ref) <=
        ($past(o_speed_ref[W-1]) ? -$past(o_speed_ref) : $past(o_speed_ref)))
        else $error("model speed grew during deceleration");
    link_decel_a: assert property (
        state_reg == ST_RUN && i_link_lost && !i_link_lost_brake && decel_en
        && !(i_alarm_evt && i_alarm_brake) |=> state_reg == ST_DECEL)
        else $error("link loss did not decelerate");
    nodecel_stop_a: assert property (
        state_reg == ST_RUN && stop_req && mode_reg == 4'h0
        |=> state_reg == ST_STOP ##1 o_drive.dyn_brake)
        else $error("disabled mode used a ramp");
    // helper: cycles spent in ST_WAIT, cleared in ST_STOP, bounds the cutoff wait
    logic [W:0] cut_cnt_reg;
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cut_cnt_reg <= '0;
        else if (state_reg == ST_WAIT)
            cut_cnt_reg <= cut_cnt_reg + (W+1)'(1);
        else
            cut_cnt_reg <= '0;
    end

    zero_cut_a: assert property (
        state_reg == ST_DECEL && below_zero && !sto_alarm && !i_alarm_evt
        |=> !o_drive.interlock && state_reg == ST_WAIT)
        else $error("no interlock drop at zero speed");
    cutoff_end_a: assert property (
        state_reg == ST_WAIT && cut_cnt_reg == {1'b0, delay_reg}
        |=> o_drive.dyn_brake && !o_drive.power_on)
        else $error("no cutoff after delay");
    wait_bound_a: assert property (
        state_reg == ST_WAIT |-> cut_cnt_reg <= {1'b0, delay_reg})
        else $error("cutoff wait overran delay");
    delay_hold_a: assert property (
        state_reg == ST_WAIT && wait_cnt_reg < delay_reg |=> o_drive.power_on)
        else $error("power cut before delay");
    fault_hold_a: assert property (
        alarm_reg && !clear_cmd && state_reg != ST_DECEL |=> o_speed_ref == '0 && o_fault_output)
        else $error("host command used during alarm");

    decel_run_c: cover property (state_reg == ST_DECEL ##1 state_reg == ST_WAIT);
    brake_now_c: cover property (state_reg == ST_RUN ##1 state_reg == ST_STOP);
    alarm_clr_c: cover property (alarm_reg ##1 !alarm_reg);
    sto_alarm_c: cover property (sto_alarm);
endmodule

// >>> verif/fss_host_model.sv
// Purpose: host controller model, apb master toward the sequencer
// Assumes: answer sampled on pready at a rising edge
// Notes: o_hang rises when an answer never comes
`timescale 1ns/100ps
`include "fss_consts.svh"
module fss_host_model (
    // clock
    input wire logic i_clock,
    // apb master side
    input wire logic i_pready,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    // watchdog
    output logic o_hang
);
    // idle bus at time zero
    initial
    begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
        o_hang = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // one transfer, held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (i_pready !== 1'b1 && n < 64);
        if (i_pready !== 1'b1)
            o_hang <= 1'b1;
        // released lines stop showing the old word
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask

    // error or processor reset command
    task reset_cmd(input logic [1:0] kind);
        xfer(1'b1, `FSS_CMD_OFS, {30'h0, kind});
    endtask
endmodule

// >>> verif/tb_top.sv
// Purpose: self-checking bench of the alarm and forced-stop sequencer
// Assumes: zero-wait apb, stop sources sampled each rising edge
// Notes: read data checked from a queue by a monitor process
`timescale 1ns/100ps
`include "fss_consts.svh"
module tb_top
    import fss_pkg::*;
;
    logic clk, rst, psel, pen, pwr, pready, slverr, fs_n, sto_n, lost, lost_brk;
    logic aevt, abrk, cause, tq, irq, fault, hang;
    logic [7:0] paddr, acode, code_o;
    logic [31:0] pwdata, prdata;
    logic signed [15:0] hspd, mspd, sref;
    fss_drive_type drv;
    int errors, checked, seed, s1;
    logic [31:0] exp_q[$];

    fss_sequencer u_fss_sequencer (.i_clock(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr),
        .i_forced_stop_input_n(fs_n), .i_safe_torque_off_input_n(sto_n),
        .i_link_lost(lost), .i_link_lost_brake(lost_brk), .i_alarm_evt(aevt),
        .i_alarm_code(acode), .i_alarm_brake(abrk), .i_alarm_cause(cause),
        .i_torque_mode(tq), .i_host_speed(hspd), .i_motor_speed(mspd),
        .o_speed_ref(sref), .o_drive(drv), .o_fault_output(fault),
        .o_alarm_code(code_o), .o_irq(irq));
    fss_host_model u_fss_host_model (.i_clock(clk), .i_pready(pready), .o_psel(psel),
        .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_hang(hang));

    ////////////////////////////////////////////////////////////////
    // clock and hang guards
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish;
    end
    always @(posedge clk)
        if (hang === 1'b1)
        begin
            errors++;
            tally_and_finish;
        end

    // monitor: read data against oldest note, error flag on every access
    always @(posedge clk)
        if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1)
        begin
            chk({31'h0, slverr}, {31'h0, paddr > 8'h1c});
            if (pwr === 1'b0 && exp_q.size() > 0)
                chk(prdata, exp_q.pop_front());
        end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_fss_host_model.xfer(1'b0, a, 32'h0);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_fss_host_model.xfer(1'b1, a, d);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task tally_and_finish;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst = 1'b1;
        {fs_n, sto_n, lost, lost_brk, aevt, abrk, cause, tq} = 8'hc0;
        acode = 8'h00;
        hspd = 16'sd0;
        mspd = 16'sd1000;
        seed = 32'h97534f86;
        errors = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped place
        rd(`FSS_CTRL_OFS, 32'h2);
        rd(`FSS_DECEL_OFS, 32'h10);
        rd(`FSS_ZERO_OFS, 32'h32);
        rd(`FSS_DELAY_OFS, 32'h0);
        rd(8'h20, 32'h0);
        wr(`FSS_DELAY_OFS, 32'h3);
        wr(`FSS_DECEL_OFS, 32'h20);
        @(posedge clk);
        hspd <= 16'($random(seed));
        tick(3);
        chk(sref, hspd);
        // forced stop: ramp, interlock off, delayed cutoff
        @(posedge clk);
        fs_n <= 1'b0;
        tick(1);
        chk({29'h0, drv}, 32'h5);
        tick(2);
        s1 = sref;
        tick(1);
        chk(32'(s1 - sref), 32'h20);
        @(posedge clk);
        mspd <= 16'sd5;
        tick(1);
        chk({29'h0, drv}, 32'h4);
        tick(3);
        chk({29'h0, drv}, 32'h4);
        tick(1);
        chk({29'h0, drv}, 32'h2);
        rd(`FSS_ISTAT_OFS, 32'h6);
        wr(`FSS_ISTAT_OFS, 32'h7);
        rd(`FSS_ISTAT_OFS, 32'h0);
        @(posedge clk);
        fs_n <= 1'b1;
        mspd <= 16'sd1000;
        tick(3);
        chk({29'h0, drv}, 32'h5);
        // torque off during deceleration, refused and accepted clears
        @(posedge clk);
        fs_n <= 1'b0;
        tick(2);
        @(posedge clk);
        sto_n <= 1'b0;
        tick(1);
        chk({29'h0, drv}, 32'h2);
        @(posedge clk);
        fs_n <= 1'b1;
        hspd <= 16'($random(seed));
        rd(`FSS_STAT_OFS, 32'h3f2b);
        tick(0);
        chk({24'h0, code_o}, 32'h3f);
        chk(sref, 32'h0);
        chk({31'h0, fault}, 32'h1);
        wr(`FSS_IMASK_OFS, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h1);
        u_fss_host_model.reset_cmd(2'h1);
        tick(2);
        chk({31'h0, fault}, 32'h1);
        @(posedge clk);
        sto_n <= 1'b1;
        cause <= 1'b1;
        u_fss_host_model.reset_cmd(2'h2);
        tick(2);
        chk({31'h0, fault}, 32'h1);
        @(posedge clk);
        cause <= 1'b0;
        u_fss_host_model.reset_cmd(2'h2);
        tick(2);
        chk({31'h0, fault}, 32'h0);
        wr(`FSS_ISTAT_OFS, 32'h7);
        tick(1);
        chk({31'h0, irq}, 32'h0);
        // stop sources: brake alarm, torque mode, mode 0, link kinds, plain alarm
        hspd <= 16'sd0;
        for (int i = 0; i < 6; i++)
        begin
            if (i == 2)
                wr(`FSS_CTRL_OFS, 32'h0);
            @(posedge clk);
            aevt <= (i == 0 || i == 5);
            abrk <= (i == 0);
            acode <= 8'h11;
            tq <= (i == 1);
            fs_n <= !(i == 1 || i == 2);
            lost <= (i == 3 || i == 4);
            lost_brk <= (i == 3);
            mspd <= 16'sd1000;
            tick(1);
            chk({29'h0, drv}, (i >= 4) ? 32'h5 : 32'h2);
            @(posedge clk);
            aevt <= 1'b0;
            abrk <= 1'b0;
            #1;
            chk({31'h0, sref != 16'sd0}, {31'h0, i >= 4});
            chk({24'h0, code_o}, (i == 0 || i == 5) ? 32'h11 : 32'h0);
            @(posedge clk);
            {tq, lost, lost_brk, fs_n} <= 4'h1;
            mspd <= 16'sd5;
            wr(`FSS_CTRL_OFS, 32'h2);
            u_fss_host_model.reset_cmd(2'h3);
            tick(10);
            chk({29'h0, drv}, 32'h5);
        end
        tally_and_finish;
    end
endmodule
